// ### src/pxc_irq_cfg_regs.sv
// Configuration register slice of an 8-bit serial port expander.
// Assumes the serial engine presents one request per cycle and muxes read data
// of registers outside this slice itself.
`timescale 1ns/10ps
module pxc_irq_cfg_regs
  import pxc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_nrst,
  // Requests from the serial engine.
  input wire pxc_req_t i_req,
  // Port state from the rest of the device.
  input wire logic [WIDTH-1:0] i_pin_direction,
  input wire logic [WIDTH-1:0] i_port_level,
  // Answers to the serial engine.
  output logic [7:0] o_ptr,
  output logic [7:0] o_rdata,
  output logic o_rdata_hit,
  output pxc_cfg_t o_cfg,
  // Pad controls.
  output logic [WIDTH-1:0] o_pullup_on,
  output logic o_irq_out,
  output logic o_irq_oe,
  // Status.
  output logic [WIDTH-1:0] o_irq_pending_flags
);

  // True when the pointer addresses the given offset.
  function automatic logic reg_hit(input logic [7:0] ptr, input logic [7:0] off);
    reg_hit = (ptr == off);
  endfunction : reg_hit

  logic [7:0] ptr;
  logic [WIDTH-1:0] change_irq_enable_q;
  logic [WIDTH-1:0] default_compare_value_q;
  logic [WIDTH-1:0] compare_mode_select_q;
  logic [7:0] device_configuration_q;
  logic [WIDTH-1:0] pullup_enable_q;
  logic [WIDTH-1:0] flags;
  logic [WIDTH-1:0] flags_d;
  logic [WIDTH-1:0] capture;
  logic [WIDTH-1:0] is_input;
  logic irq_clear;
  logic irq_any_d;
  logic cfg_open_drain;
  logic cfg_active_level;
  logic [7:0] rdata_d;
  logic rdata_hit_d;
  logic [7:0] ptr_q;
  logic [7:0] rdata_q;
  logic rdata_hit_q;
  pxc_cfg_t cfg_q;
  logic [WIDTH-1:0] pullup_on_q;
  logic irq_out_q;
  logic irq_oe_q;
  logic [WIDTH-1:0] flags_q;

  assign is_input = i_pin_direction;

  pxc_addr_ptr u_ptr (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_load(i_req.ptr_load),
    .i_value(i_req.ptr_value),
    .i_byte_done(i_req.byte_done),
    .i_seq_disable(device_configuration_q[PXC_CFG_SEQ_DIS_BIT]),
    .o_ptr(ptr)
  );

  // Writable registers; a write lands on the register under the pointer.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      change_irq_enable_q <= PXC_RST_CHG_EN[WIDTH-1:0];
    end else if (i_req.wr_stb && reg_hit(ptr, PXC_OFF_CHG_EN)) begin
      change_irq_enable_q <= i_req.wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      default_compare_value_q <= PXC_RST_DEF_CMP[WIDTH-1:0];
    end else if (i_req.wr_stb && reg_hit(ptr, PXC_OFF_DEF_CMP)) begin
      default_compare_value_q <= i_req.wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      compare_mode_select_q <= PXC_RST_CMP_MODE[WIDTH-1:0];
    end else if (i_req.wr_stb && reg_hit(ptr, PXC_OFF_CMP_MODE)) begin
      compare_mode_select_q <= i_req.wdata[WIDTH-1:0];
    end
  end

  // Unimplemented bits are masked on the way in, so they also read back zero.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      device_configuration_q <= PXC_RST_DEV_CFG;
    end else if (i_req.wr_stb && reg_hit(ptr, PXC_OFF_DEV_CFG)) begin
      device_configuration_q <= i_req.wdata & PXC_CFG_WMASK;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pullup_enable_q <= PXC_RST_PULLUP[WIDTH-1:0];
    end else if (i_req.wr_stb && reg_hit(ptr, PXC_OFF_PULLUP)) begin
      pullup_enable_q <= i_req.wdata[WIDTH-1:0];
    end
  end

  // The flag register has no write path at all, so writes there are dropped.
  // Only a read of capture or port clears; writes to them are not decoded here.
  assign irq_clear = i_req.rd_stb &&
                     (reg_hit(ptr, PXC_OFF_CAPTURE) || reg_hit(ptr, PXC_OFF_PORT));

  pxc_irq_detect #(
    .WIDTH(WIDTH)
  ) u_detect (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_enable(change_irq_enable_q),
    .i_default(default_compare_value_q),
    .i_mode(compare_mode_select_q),
    .i_is_input(is_input),
    .i_pins(i_port_level),
    .i_clear(irq_clear),
    .o_flags(flags),
    .o_flags_d(flags_d),
    .o_capture(capture)
  );

  assign irq_any_d = |flags_d;
  assign cfg_open_drain = device_configuration_q[PXC_CFG_OPEN_DRAIN_BIT];
  assign cfg_active_level = device_configuration_q[PXC_CFG_ACT_LEVEL_BIT];

  // Read data for the register under the pointer; other offsets are left to
  // the serial engine, which sees o_rdata_hit low for them.
  always_comb begin
    rdata_d = 8'h00;
    rdata_hit_d = 1'b1;
    case (ptr)
      PXC_OFF_CHG_EN: rdata_d = 8'(change_irq_enable_q);
      PXC_OFF_DEF_CMP: rdata_d = 8'(default_compare_value_q);
      PXC_OFF_CMP_MODE: rdata_d = 8'(compare_mode_select_q);
      PXC_OFF_DEV_CFG: rdata_d = device_configuration_q & PXC_CFG_WMASK;
      PXC_OFF_PULLUP: rdata_d = 8'(pullup_enable_q);
      PXC_OFF_FLAGS: rdata_d = 8'(flags);
      PXC_OFF_CAPTURE: rdata_d = 8'(capture);
      default: begin
        rdata_d = 8'h00;
        rdata_hit_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= 8'h00;
      rdata_hit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rdata_hit_q <= rdata_hit_d;
    end
  end

  // Registered copy of the pointer, so the engine sees it with its read data.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ptr_q <= PXC_RST_PTR;
    end else begin
      ptr_q <= ptr;
    end
  end

  // Configuration fields for the serial engine, the data pad and the interrupt pad.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_q <= '0;
    end else begin
      cfg_q.sequential_disable <= device_configuration_q[PXC_CFG_SEQ_DIS_BIT];
      cfg_q.slew_control_disable <= device_configuration_q[PXC_CFG_SLEW_DIS_BIT];
      // The I2C variant ignores this bit and always matches its address pins.
      cfg_q.address_pin_enable <= device_configuration_q[PXC_CFG_ADDR_EN_BIT];
      cfg_q.irq_open_drain <= cfg_open_drain;
      cfg_q.irq_active_level <= cfg_active_level;
    end
  end

  // Output pins never get a pull-up, whatever the enable says.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pullup_on_q <= '0;
    end else begin
      pullup_on_q <= pullup_enable_q & is_input;
    end
  end

  // Open drain only pulls low while active and floats otherwise; push-pull
  // always drives, at the chosen level.
  // In reset the pin shows the idle level of the reset configuration, which is
  // push-pull and active low, so no false interrupt is seen while in reset.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_out_q <= 1'b1;
      irq_oe_q <= 1'b1;
    end else if (cfg_open_drain) begin
      irq_out_q <= 1'b0;
      irq_oe_q <= irq_any_d;
    end else begin
      irq_out_q <= cfg_active_level ? irq_any_d : ~irq_any_d;
      irq_oe_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign o_ptr = ptr_q;
  assign o_rdata = rdata_q;
  assign o_rdata_hit = rdata_hit_q;
  assign o_cfg = cfg_q;
  assign o_pullup_on = pullup_on_q;
  assign o_irq_out = irq_out_q;
  assign o_irq_oe = irq_oe_q;
  assign o_irq_pending_flags = flags_q;

endmodule : pxc_irq_cfg_regs

// ### src/pxc_pkg.sv
// Shared constants and carrier types for the port expander configuration slice.
// Assumes an 8-bit register map addressed by a byte-wide pointer that the serial engine loads into the slice.
package pxc_pkg;

  // Register offsets.
  localparam logic [7:0] PXC_OFF_DIRECTION = 8'h00;
  localparam logic [7:0] PXC_OFF_CHG_EN = 8'h02;
  localparam logic [7:0] PXC_OFF_DEF_CMP = 8'h03;
  localparam logic [7:0] PXC_OFF_CMP_MODE = 8'h04;
  localparam logic [7:0] PXC_OFF_DEV_CFG = 8'h05;
  localparam logic [7:0] PXC_OFF_PULLUP = 8'h06;
  localparam logic [7:0] PXC_OFF_FLAGS = 8'h07;
  localparam logic [7:0] PXC_OFF_CAPTURE = 8'h08;
  localparam logic [7:0] PXC_OFF_PORT = 8'h09;
  localparam logic [7:0] PXC_OFF_LAST = 8'h0A;

  // Field positions inside the device configuration register.
  localparam int PXC_CFG_SEQ_DIS_BIT = 5;
  localparam int PXC_CFG_SLEW_DIS_BIT = 4;
  localparam int PXC_CFG_ADDR_EN_BIT = 3;
  localparam int PXC_CFG_OPEN_DRAIN_BIT = 2;
  localparam int PXC_CFG_ACT_LEVEL_BIT = 1;
  localparam logic [7:0] PXC_CFG_WMASK = 8'h3E;

  // Values after reset.
  localparam logic [7:0] PXC_RST_CHG_EN = 8'h00;
  localparam logic [7:0] PXC_RST_DEF_CMP = 8'h00;
  localparam logic [7:0] PXC_RST_CMP_MODE = 8'h00;
  localparam logic [7:0] PXC_RST_DEV_CFG = 8'h00;
  localparam logic [7:0] PXC_RST_PULLUP = 8'h00;
  localparam logic [7:0] PXC_RST_FLAGS = 8'h00;
  localparam logic [7:0] PXC_RST_CAPTURE = 8'h00;
  localparam logic [7:0] PXC_RST_PTR = 8'h00;

  // Requests from the serial protocol engine, one cycle each.
  typedef struct packed {
    logic ptr_load;
    logic [7:0] ptr_value;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] wdata;
    logic byte_done;
  } pxc_req_t;

  // Decoded configuration handed to the serial engine and pads.
  typedef struct packed {
    logic sequential_disable;
    logic slew_control_disable;
    logic address_pin_enable;
    logic irq_open_drain;
    logic irq_active_level;
  } pxc_cfg_t;

endpackage : pxc_pkg

// ### src/pxc_addr_ptr.sv
// Serial register address pointer with optional auto-increment.
// Assumes the engine pulses byte_done once after each data byte.
`timescale 1ns/10ps
module pxc_addr_ptr
  import pxc_pkg::*;
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_nrst,
  // Control.
  input wire logic i_load,
  input wire logic [7:0] i_value,
  input wire logic i_byte_done,
  input wire logic i_seq_disable,
  // Pointer.
  output logic [7:0] o_ptr
);

  logic [7:0] ptr_q;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ptr_q <= PXC_RST_PTR;
    end else if (i_load) begin
      ptr_q <= i_value;
    end else if (i_byte_done && !i_seq_disable) begin
      // The pointer rolls over to zero after the last register.
      if (ptr_q >= PXC_OFF_LAST) begin
        ptr_q <= PXC_RST_PTR;
      end else begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  assign o_ptr = ptr_q;

endmodule : pxc_addr_ptr

// ### src/pxc_irq_detect.sv
// Per-pin interrupt-on-change detection, pending flags and port capture.
// Assumes pin levels and direction bits are synchronous to i_clock.
`timescale 1ns/10ps
module pxc_irq_detect
  import pxc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_nrst,
  // Configuration.
  input wire logic [WIDTH-1:0] i_enable,
  input wire logic [WIDTH-1:0] i_default,
  input wire logic [WIDTH-1:0] i_mode,
  input wire logic [WIDTH-1:0] i_is_input,
  // Port and clear.
  input wire logic [WIDTH-1:0] i_pins,
  input wire logic i_clear,
  // State.
  output logic [WIDTH-1:0] o_flags,
  output logic [WIDTH-1:0] o_flags_d,
  output logic [WIDTH-1:0] o_capture
);

  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;
  logic [WIDTH-1:0] cap_q;
  logic [WIDTH-1:0] ref_val;
  logic [WIDTH-1:0] cond;
  logic active_q;

  assign ref_val = (i_mode & i_default) | (~i_mode & prev_q);
  // Output pins are masked out entirely.
  assign cond = i_enable & i_is_input & (i_pins ^ ref_val);
  // A new condition wins over a clear in the same cycle.
  assign flags_d = (flags_q & {WIDTH{~i_clear}}) | cond;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_q <= '0;
    end else begin
      prev_q <= i_pins;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_q <= PXC_RST_FLAGS[WIDTH-1:0];
      active_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      active_q <= |flags_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cap_q <= PXC_RST_CAPTURE[WIDTH-1:0];
    end else if ((|cond) && (!active_q || i_clear)) begin
      cap_q <= i_pins;
    end
  end

  assign o_flags = flags_q;
  assign o_flags_d = flags_d;
  assign o_capture = cap_q;

endmodule : pxc_irq_detect

// ### bench/pxc_irq_cfg_regs_asserts.sv
// Concurrent checks on the ports of the configuration slice.
// Assumes it is bound onto pxc_irq_cfg_regs and shares its WIDTH.
`timescale 1ns/10ps
module pxc_irq_cfg_regs_asserts
  import pxc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_nrst,
  // Watched ports.
  input wire pxc_req_t i_req,
  input wire logic [WIDTH-1:0] i_pin_direction,
  input wire logic [WIDTH-1:0] i_port_level,
  input wire logic [7:0] o_ptr,
  input wire logic [7:0] o_rdata,
  input wire logic o_rdata_hit,
  input wire pxc_cfg_t o_cfg,
  input wire logic [WIDTH-1:0] o_pullup_on,
  input wire logic o_irq_out,
  input wire logic o_irq_oe,
  input wire logic [WIDTH-1:0] o_irq_pending_flags
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  wire logic any_flag = |o_irq_pending_flags;
  // The pin is registered on the same edge as the exported settings; only settled settings are judged.
  a_irq_push_pull: assert property ($stable(o_cfg)[*3] ##0 !o_cfg.irq_open_drain |->
    o_irq_oe && o_irq_out == (o_cfg.irq_active_level ? any_flag : !any_flag))
    else $error("push-pull interrupt pin wrong");
  a_irq_open_drain: assert property ($stable(o_cfg)[*3] ##0 o_cfg.irq_open_drain |->
    !o_irq_out && o_irq_oe == any_flag)
    else $error("open-drain interrupt pin wrong");
  a_pullup_input_only: assert property ((o_pullup_on & ~$past(i_pin_direction)) == '0)
    else $error("pull-up on an output pin");
  a_flag_input_only: assert property (
    ((o_irq_pending_flags & ~$past(o_irq_pending_flags)) & ~$past(i_pin_direction)) == '0)
    else $error("flag raised by an output pin");
  a_flag_clear_read: assert property (|($past(o_irq_pending_flags) & ~o_irq_pending_flags)
    |-> $past(i_req.rd_stb) && (o_ptr == PXC_OFF_CAPTURE || o_ptr == PXC_OFF_PORT))
    else $error("flag dropped without a read");
  a_ptr_hold: assert property (i_req.byte_done && !i_req.ptr_load ##1
    o_cfg.sequential_disable |=> $stable(o_ptr))
    else $error("pointer moved while held");
  a_ptr_step: assert property (i_req.byte_done && !i_req.ptr_load ##1
    !o_cfg.sequential_disable |=>
    o_ptr == ($past(o_ptr) == PXC_OFF_LAST ? 8'h00 : $past(o_ptr) + 8'h01))
    else $error("pointer did not advance by one");
  a_cfg_zero_bits: assert property (o_ptr == PXC_OFF_DEV_CFG && $past(o_ptr) == PXC_OFF_DEV_CFG
    |-> o_rdata[7:6] == 2'h0 && !o_rdata[0])
    else $error("unused configuration bits read nonzero");
  a_reset_clear: assert property ($rose(i_nrst) |->
    o_cfg == '0 && o_pullup_on == '0 && o_irq_pending_flags == '0 && o_irq_out && o_irq_oe)
    else $error("state not cleared by reset");
  c_open_drain_active: cover property (o_cfg.irq_open_drain && any_flag);
  c_high_active: cover property (o_cfg.irq_active_level && o_irq_out);
  c_ptr_held: cover property (i_req.byte_done ##1 o_cfg.sequential_disable);
endmodule : pxc_irq_cfg_regs_asserts

bind pxc_irq_cfg_regs pxc_irq_cfg_regs_asserts #(.WIDTH(WIDTH)) chk_u (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_req(i_req), .i_pin_direction(i_pin_direction),
  .i_port_level(i_port_level), .o_ptr(o_ptr), .o_rdata(o_rdata), .o_rdata_hit(o_rdata_hit),
  .o_cfg(o_cfg), .o_pullup_on(o_pullup_on), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe),
  .o_irq_pending_flags(o_irq_pending_flags));

// ### bench/pxc_engine_model.sv
// Stand-in for the serial protocol engine: turns register calls into requests.
// Assumes one clock; each request lasts one cycle with an idle cycle after it.
`timescale 1ns/10ps
module pxc_engine_model
  import pxc_pkg::*;
(
  // Clock.
  input wire logic i_clock,
  // Read data from the slice.
  input wire logic [7:0] i_rdata,
  // Requests to the slice.
  output pxc_req_t o_req
);
  initial o_req = '0;
  task automatic send(input pxc_req_t r);
    @(negedge i_clock);
    o_req = r;
    @(negedge i_clock);
    o_req = '0;
  endtask : send
  task automatic load(input logic [7:0] a);
    pxc_req_t r;
    r = '0;
    r.ptr_load = 1'b1;
    r.ptr_value = a;
    send(r);
  endtask : load
  task automatic wbyte(input logic [7:0] d);
    pxc_req_t r;
    r = '0;
    r.wr_stb = 1'b1;
    r.wdata = d;
    r.byte_done = 1'b1;
    send(r);
  endtask : wbyte
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    load(a);
    wbyte(d);
  endtask : write
  // Data is taken before the read strobe, since the strobe may clear the flags.
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    pxc_req_t r;
    load(a);
    repeat (2) @(negedge i_clock);
    d = i_rdata;
    r = '0;
    r.rd_stb = 1'b1;
    r.byte_done = 1'b1;
    send(r);
  endtask : read
endmodule : pxc_engine_model

// ### bench/pxc_irq_cfg_regs_tb.sv
// Self-checking bench for the configuration slice.
// Assumes the engine model drives requests; pins are driven here at the falling edge.
`timescale 1ns/10ps
module pxc_irq_cfg_regs_tb;
  import pxc_pkg::*;
  logic i_clock, i_nrst, irq_out, irq_oe, hit;
  logic [7:0] dir, lvl, ptr, rdata, pu_on, flags, v;
  pxc_req_t req;
  pxc_cfg_t cfg;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] cv[6] = '{8'hFF, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02};
  pxc_irq_cfg_regs #(.WIDTH(8)) dut_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_req(req),
    .i_pin_direction(dir), .i_port_level(lvl), .o_ptr(ptr), .o_rdata(rdata),
    .o_rdata_hit(hit), .o_cfg(cfg), .o_pullup_on(pu_on), .o_irq_out(irq_out),
    .o_irq_oe(irq_oe), .o_irq_pending_flags(flags));
  pxc_engine_model eng_u (.i_clock(i_clock), .i_rdata(rdata), .o_req(req));
  always #4 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    eng_u.read(a, d);
    chk(d, exp);
  endtask : rdc
  task automatic settle;
    repeat (2) @(negedge i_clock);
  endtask : settle
  // Expected pin for a pending state and a configuration value.
  task automatic pin_chk(input logic p, input logic [7:0] c);
    chk(8'(irq_out), 8'(c[2] ? 1'b0 : (p ? c[1] : !c[1])));
    chk(8'(irq_oe), 8'(c[2] ? p : 1'b1));
  endtask : pin_chk
  initial begin
    i_clock = 1'b0;
    i_nrst = 1'b0;
    dir = 8'hFF;
    lvl = 8'h00;
    repeat (6) @(negedge i_clock);
    i_nrst = 1'b1;
    settle();
    pin_chk(1'b0, 8'h00);
    for (int a = 2; a < 7; a++) rdc(8'(a), 8'h00);
    for (int a = 0; a < 11; a++) begin
      eng_u.load(8'(a));
      settle();
      chk(ptr, 8'(a));
      chk(8'(hit), 8'(a >= 2 && a <= 8));
    end
    $display("test reset done");
    for (int a = 2; a < 7; a++) if (a != 5) begin
      eng_u.write(8'(a), 8'hA5);
      rdc(8'(a), 8'hA5);
    end
    for (int i = 0; i < 6; i++) begin
      eng_u.write(PXC_OFF_DEV_CFG, cv[i]);
      rdc(PXC_OFF_DEV_CFG, cv[i] & 8'h3E);
      chk(8'({cfg, 1'b0}), cv[i] & 8'h3E);
    end
    for (int a = 2; a < 7; a++) eng_u.write(8'(a), 8'h00);
    eng_u.read(PXC_OFF_CAPTURE, v);
    $display("test registers done");
    eng_u.write(PXC_OFF_DEF_CMP, 8'h11);
    eng_u.wbyte(8'h22);
    rdc(PXC_OFF_CMP_MODE, 8'h22);
    eng_u.write(PXC_OFF_DEV_CFG, 8'h20);
    eng_u.write(PXC_OFF_DEF_CMP, 8'h33);
    eng_u.wbyte(8'h44);
    rdc(PXC_OFF_DEF_CMP, 8'h44);
    rdc(PXC_OFF_CMP_MODE, 8'h22);
    eng_u.write(PXC_OFF_DEV_CFG, 8'h00);
    eng_u.write(PXC_OFF_DEF_CMP, 8'h00);
    eng_u.write(PXC_OFF_CMP_MODE, 8'h00);
    $display("test pointer done");
    eng_u.write(PXC_OFF_PULLUP, 8'h0F);
    dir = 8'h33;
    settle();
    chk(pu_on, 8'h03);
    $display("test pull-up done");
    dir = 8'h0D;
    eng_u.write(PXC_OFF_CHG_EN, 8'h07);
    lvl = 8'h0A;
    settle();
    chk(flags, 8'h00);
    lvl = 8'h0B;
    settle();
    chk(flags, 8'h01);
    pin_chk(1'b1, 8'h00);
    lvl = 8'h0F;
    settle();
    chk(flags, 8'h05);
    for (int a = 7; a < 10; a++) eng_u.write(8'(a), 8'hFF);
    rdc(PXC_OFF_FLAGS, 8'h05);
    rdc(PXC_OFF_CAPTURE, 8'h0B);
    chk(flags, 8'h00);
    $display("test pin change done");
    eng_u.write(PXC_OFF_CMP_MODE, 8'h01);
    settle();
    chk(flags, 8'h01);
    eng_u.read(PXC_OFF_PORT, v);
    chk(flags, 8'h01);
    $display("test default compare done");
    for (int p = 1; p >= 0; p--) begin
      lvl = p[0] ? 8'h0F : 8'h0E;
      eng_u.read(PXC_OFF_CAPTURE, v);
      chk(flags, 8'(p[0]));
      for (int c = 0; c < 8; c += 2) begin
        eng_u.write(PXC_OFF_DEV_CFG, 8'(c));
        settle();
        pin_chk(p[0], 8'(c));
      end
    end
    $display("test interrupt pin done");
    i_nrst = 1'b0;
    settle();
    i_nrst = 1'b1;
    settle();
    rdc(PXC_OFF_DEV_CFG, 8'h00);
    rdc(PXC_OFF_CHG_EN, 8'h00);
    chk(flags, 8'h00);
    $display("test second reset done");
    final_report();
  end
endmodule : pxc_irq_cfg_regs_tb
